/* core/ext_index_defines.vh */
`ifndef EXT_INDEX_DEFINES_VH
`define EXT_INDEX_DEFINES_VH

// ----------------------------------------------------------------
// Opcode fields
// ----------------------------------------------------------------
`define OPC_HI_MSB 15
`define OPC_HI_LSB 8
`define NIB_MSB 15
`define NIB_LSB 12
`define SEL_MSB 7
`define SEL_LSB 6
`define LIT_MSB 5
`define LIT_LSB 0
`define FILE_MSB 7
`define FILE_LSB 0
`define ACC_BIT 8
`define DEST_BIT 9
`define SUB_MSB 11
`define SUB_LSB 9
`define LIT_W 6

// ----------------------------------------------------------------
// Opcode codes
// ----------------------------------------------------------------
`define OPC_SUB_PTR 8'hE9
`define SEL_PTR0 2'h0
`define SEL_PTR1 2'h1
`define SEL_FRAME 2'h2
`define SEL_RETURN 2'h3
`define NIB_MISC 4'h0
`define NIB_BYTE_LO 4'h1
`define NIB_BYTE_HI 4'h5
`define NIB_NO_DEST 4'h6
`define NIB_TOGGLE 4'h7
`define NIB_BIT_LO 4'h8
`define NIB_BIT_HI 4'hB
`define SUB_MULTIPLY 3'h1
`define SUB_DECREMENT_LO 3'h2
`define SUB_DECREMENT_HI 3'h3
`define INDEX_LIMIT 8'h5F

// ----------------------------------------------------------------
// Register port map and reset values
// ----------------------------------------------------------------
`define REG_CONFIG 4'h0
`define REG_BANK 4'h1
`define REG_PTR0 4'h2
`define REG_PTR1 4'h3
`define REG_PTR2 4'h4
`define REG_STATUS 4'h5
`define CFG_EXT_BIT 0
`define CONFIG_RST 1'b0
`define STAT_INDEXED_BIT 12
`define STAT_NOP_BIT 13

`endif

/* core/ext_index_decoder.v */
// The register offsets and the strobed register port were left to the implementer.
`timescale 1ns/1ps

`include "ext_index_defines.vh"

// Overview of operation
// (RL1) Pointer minus 6-bit literal, flags untouched
// (RL2) Decode E9h upper byte, select, literal
// (RL3) Frame pointer minus literal, then return
// (RL4) Return takes two cycles, second idle
// (RL5) Select 3 means frame pointer return
// (RL6) Extended enable also enables indexed addressing
// (RL7) Disabled: access bank or banked address
// (RL8) Enabled, access, operand <=5Fh: frame offset
// (RL9) Remap only byte and bit instructions
// (RL10) Frame pointer zero keeps original mapping
// (RL11) Destination bit keeps normal meaning
// (RL12) Indexed address is frame pointer plus k
// (RL13) Config bit resets to disabled
module ext_index_decoder #(
	parameter ADDR_W = 12,
	parameter PC_W = 21,
	parameter DATA_W = 16
) (
	// Clock, reset, enable
	input wire ref_clk,
	input wire rst_n,
	input wire clk_en,
	// Instruction fetch
	input wire instr_valid,
	input wire [15:0] instr_word,
	output wire instr_req,
	// Return stack
	input wire [PC_W-1:0] top_of_return_stack,
	output reg stack_pop_q,
	output reg pc_load_q,
	output reg [PC_W-1:0] pc_target_q,
	// Data access
	output reg [ADDR_W-1:0] data_addr_q,
	output reg data_addr_valid_q,
	output reg data_addr_indexed_q,
	output reg dest_file_q,
	// Instruction cycle
	output reg [3:0] phase_q,
	output reg nop_cycle_q,
	// Register port
	input wire [3:0] reg_addr,
	input wire [DATA_W-1:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [DATA_W-1:0] reg_rdata_q
);

	localparam BANK_W = ADDR_W - 8;
	localparam NUM_PTR = 3;
	localparam [3:0] PH_Q1 = 4'h1;
	localparam [3:0] PH_Q2 = 4'h2;
	localparam [3:0] PH_Q3 = 4'h4;
	localparam [3:0] PH_Q4 = 4'h8;

	// ----------------------------------------------------------------
	// Decode functions
	// ----------------------------------------------------------------

	// Byte and bit classes carry the access select bit
	function has_access;
		input [15:0] w;
		reg [3:0] nib;
		reg [2:0] sub;
		begin
			nib = w[`NIB_MSB:`NIB_LSB];
			sub = w[`SUB_MSB:`SUB_LSB];
			has_access = 1'b0;
			if (nib == `NIB_MISC)
				has_access = (sub == `SUB_MULTIPLY) || (sub == `SUB_DECREMENT_LO) ||
					(sub == `SUB_DECREMENT_HI);
			else if (nib >= `NIB_BYTE_LO && nib <= `NIB_TOGGLE)
				has_access = 1'b1;
			else if (nib >= `NIB_BIT_LO && nib <= `NIB_BIT_HI)
				has_access = 1'b1;
		end
	endfunction

	// Byte instructions with a result destination select
	function has_dest;
		input [15:0] w;
		reg [3:0] nib;
		reg [2:0] sub;
		begin
			nib = w[`NIB_MSB:`NIB_LSB];
			sub = w[`SUB_MSB:`SUB_LSB];
			has_dest = 1'b0;
			if (nib == `NIB_MISC)
				has_dest = (sub == `SUB_DECREMENT_LO) || (sub == `SUB_DECREMENT_HI);
			else if (nib >= `NIB_BYTE_LO && nib <= `NIB_BYTE_HI)
				has_dest = 1'b1;
		end
	endfunction

	function is_indexed;
		input [15:0] w;
		input ext;
		begin
			is_indexed = ext && has_access(w) && !w[`ACC_BIT] &&
				(w[`FILE_MSB:`FILE_LSB] <= `INDEX_LIMIT);
		end
	endfunction

	function [ADDR_W-1:0] effective_addr;
		input [15:0] w;
		input ext;
		input [ADDR_W-1:0] frame;
		input [BANK_W-1:0] bank;
		reg [7:0] f;
		begin
			f = w[`FILE_MSB:`FILE_LSB];
			if (is_indexed(w, ext))
				effective_addr = frame + {{BANK_W{1'b0}}, f}; // [RL8] [RL12] [RL10]
			else if (w[`ACC_BIT])
				effective_addr = {bank, f}; // [RL7]
			else if (f <= `INDEX_LIMIT)
				effective_addr = {{BANK_W{1'b0}}, f}; // [RL7]
			else
				effective_addr = {{BANK_W{1'b1}}, f}; // [RL7]
		end
	endfunction

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	reg ext_enable_q;
	reg [BANK_W-1:0] bank_select_register_q;
	reg [ADDR_W-1:0] file_select_pointer_q [0:NUM_PTR-1];
	reg [15:0] instr_q;
	reg active_q;
	reg nop_pending_q;
	reg [3:0] phase_d;
	reg [ADDR_W-1:0] sub_source;

	wire take_instr;
	wire is_sub_ptr;
	wire [1:0] sel_field;
	wire [1:0] ptr_index;
	wire [`LIT_W-1:0] sub_literal;
	wire sub_write;
	wire is_return;
	wire [ADDR_W-1:0] sub_result;

	// Fetch only in Q1 of a cycle that is not the idle return cycle
	assign instr_req = (phase_q == PH_Q1) && !nop_pending_q;
	assign take_instr = clk_en && instr_req && instr_valid;

	assign is_sub_ptr = active_q && (instr_q[`OPC_HI_MSB:`OPC_HI_LSB] == `OPC_SUB_PTR); // [RL2]
	assign sel_field = instr_q[`SEL_MSB:`SEL_LSB]; // [RL2]
	assign sub_literal = instr_q[`LIT_MSB:`LIT_LSB]; // [RL2]
	assign is_return = is_sub_ptr && (sel_field == `SEL_RETURN); // [RL5]
	// Return form always names the frame pointer
	assign ptr_index = is_return ? `SEL_FRAME : sel_field; // [RL5] [RL3]

	// Index 3 names no pointer; folding it keeps the read in range
	always @*
	begin
		case (ptr_index)
			`SEL_PTR0: sub_source = file_select_pointer_q[`SEL_PTR0];
			`SEL_PTR1: sub_source = file_select_pointer_q[`SEL_PTR1];
			default: sub_source = file_select_pointer_q[`SEL_FRAME];
		endcase
	end

	assign sub_result = sub_source -
		{{(ADDR_W-`LIT_W){1'b0}}, sub_literal}; // [RL1] [RL3]
	assign sub_write = clk_en && is_sub_ptr && (phase_q == PH_Q4);

	// ----------------------------------------------------------------
	// Phase sequencer
	// ----------------------------------------------------------------
	always @*
	begin
		case (phase_q)
			PH_Q1: phase_d = PH_Q2;
			PH_Q2: phase_d = PH_Q3;
			PH_Q3: phase_d = PH_Q4;
			PH_Q4: phase_d = PH_Q1;
			default: phase_d = PH_Q1;
		endcase
	end

	always @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			phase_q <= PH_Q1;
		else if (clk_en)
			phase_q <= phase_d;
	end

	// ----------------------------------------------------------------
	// Instruction capture and address generation
	// ----------------------------------------------------------------
	always @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			instr_q <= 16'h0000;
			active_q <= 1'b0;
			data_addr_q <= {ADDR_W{1'b0}};
			data_addr_valid_q <= 1'b0;
			data_addr_indexed_q <= 1'b0;
			dest_file_q <= 1'b0;
		end
		else if (clk_en)
		begin
			if (phase_q == PH_Q1)
			begin
				instr_q <= instr_word;
				active_q <= take_instr;
				if (take_instr)
				begin
					// Other classes keep the last data address
					if (has_access(instr_word))
					begin
						// Ext enable switches only the address mapping; E9h opcodes decode with it off too
						data_addr_q <= effective_addr(instr_word, ext_enable_q,
							file_select_pointer_q[`SEL_FRAME], bank_select_register_q); // [RL6]
					end
					data_addr_valid_q <= has_access(instr_word); // [RL9]
					data_addr_indexed_q <= is_indexed(instr_word, ext_enable_q); // [RL9] [RL8]
					// 0 = working register, 1 = file, also in indexed mode
					dest_file_q <= has_dest(instr_word) ? instr_word[`DEST_BIT] : 1'b1; // [RL11]
				end
				else
				begin
					data_addr_valid_q <= 1'b0;
					data_addr_indexed_q <= 1'b0;
					dest_file_q <= 1'b0;
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Return sequencing
	// ----------------------------------------------------------------
	always @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			nop_pending_q <= 1'b0;
			nop_cycle_q <= 1'b0;
			pc_load_q <= 1'b0;
			stack_pop_q <= 1'b0;
			pc_target_q <= {PC_W{1'b0}};
		end
		else if (clk_en)
		begin
			pc_load_q <= 1'b0;
			stack_pop_q <= 1'b0;
			if (sub_write && is_return)
			begin
				// Target comes from the stack top at the same Q4 edge as the subtract write
				pc_target_q <= top_of_return_stack; // [RL3]
				pc_load_q <= 1'b1; // [RL3]
				stack_pop_q <= 1'b1; // [RL3]
				nop_pending_q <= 1'b1; // [RL4]
			end
			else if (phase_q == PH_Q4)
				nop_pending_q <= 1'b0; // [RL4]
			// Visible for the full idle cycle, Q1 through Q4
			if (phase_q == PH_Q4)
				nop_cycle_q <= sub_write && is_return; // [RL4]
		end
	end

	// ----------------------------------------------------------------
	// Pointer, bank and config registers
	// ----------------------------------------------------------------

	// An instruction update beats a same-cycle software write
	genvar gi;
	generate
		for (gi = 0; gi < NUM_PTR; gi = gi + 1)
		begin : g_ptr
			always @(posedge ref_clk or negedge rst_n)
			begin
				if (!rst_n)
					file_select_pointer_q[gi] <= {ADDR_W{1'b0}};
				else if (clk_en)
				begin
					if (sub_write && (ptr_index == gi))
						file_select_pointer_q[gi] <= sub_result; // [RL1] [RL3]
					else if (reg_wr && (reg_addr == `REG_PTR0 + gi))
						file_select_pointer_q[gi] <= reg_wdata[ADDR_W-1:0];
				end
			end
		end
	endgenerate

	always @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ext_enable_q <= `CONFIG_RST; // [RL13]
			bank_select_register_q <= {BANK_W{1'b0}};
		end
		else if (clk_en && reg_wr)
		begin
			if (reg_addr == `REG_CONFIG)
				ext_enable_q <= reg_wdata[`CFG_EXT_BIT];
			if (reg_addr == `REG_BANK)
				bank_select_register_q <= reg_wdata[BANK_W-1:0];
		end
	end

	// ----------------------------------------------------------------
	// Register read port
	// ----------------------------------------------------------------

	// Data stand only in the cycle after the strobe; unmapped reads 0
	always @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			reg_rdata_q <= {DATA_W{1'b0}};
		else if (clk_en)
		begin
			reg_rdata_q <= {DATA_W{1'b0}};
			if (reg_rd)
			begin
				case (reg_addr)
					`REG_CONFIG: reg_rdata_q[`CFG_EXT_BIT] <= ext_enable_q;
					`REG_BANK: reg_rdata_q[BANK_W-1:0] <= bank_select_register_q;
					`REG_PTR0: reg_rdata_q[ADDR_W-1:0] <= file_select_pointer_q[0];
					`REG_PTR1: reg_rdata_q[ADDR_W-1:0] <= file_select_pointer_q[1];
					`REG_PTR2: reg_rdata_q[ADDR_W-1:0] <= file_select_pointer_q[2];
					`REG_STATUS:
					begin
						reg_rdata_q[ADDR_W-1:0] <= data_addr_q;
						reg_rdata_q[`STAT_INDEXED_BIT] <= data_addr_indexed_q;
						reg_rdata_q[`STAT_NOP_BIT] <= nop_cycle_q;
					end
					default: reg_rdata_q <= {DATA_W{1'b0}};
				endcase
			end
		end
	end

endmodule // ext_index_decoder

/* test/ext_index_asserts.sv */
`timescale 1ns/1ps
module ext_index_checker #(
	parameter ADDR_W = 12,
	parameter PC_W = 21,
	parameter DATA_W = 16
) (
	// Clock, reset, fetch
	input wire ref_clk,
	input wire rst_n,
	input wire clk_en,
	input wire instr_valid,
	input wire [15:0] instr_word,
	input wire instr_req,
	// Return and data outputs
	input wire [PC_W-1:0] top_of_return_stack,
	input wire stack_pop_q,
	input wire pc_load_q,
	input wire [PC_W-1:0] pc_target_q,
	input wire [ADDR_W-1:0] data_addr_q,
	input wire data_addr_valid_q,
	input wire data_addr_indexed_q,
	input wire dest_file_q,
	input wire [3:0] phase_q,
	input wire nop_cycle_q,
	// Register port
	input wire [3:0] reg_addr,
	input wire [DATA_W-1:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	input wire [DATA_W-1:0] reg_rdata_q
);
	// ----------------------------------------------------------------
	// Shadow of the enable bit, written only through the register port
	// ----------------------------------------------------------------
	reg ext_q;
	always @(posedge ref_clk or negedge rst_n)
		if (!rst_n)
			ext_q <= 1'b0;
		else if (clk_en && reg_wr && reg_addr == 4'h0)
			ext_q <= reg_wdata[0];
	wire take = clk_en && phase_q == 4'h1 && instr_req && instr_valid;
	wire byte_op = instr_word[15:12] >= 4'h1 && instr_word[15:12] <= 4'h5;
	wire acc_op = byte_op || instr_word[15:12] >= 4'h6 && instr_word[15:12] <= 4'hB;
	wire ret_op = instr_word[15:6] == 10'h3A7;
	wire low_f = instr_word[7:0] <= 8'h5F;
	default clocking @(posedge ref_clk);
	endclocking
	default disable iff (!rst_n);
	sequence s_ret_take;
		take && ret_op;
	endsequence
	sequence s_idle4;
		(pc_load_q && stack_pop_q && nop_cycle_q) ##1 (!pc_load_q && nop_cycle_q) [*3];
	endsequence
	property p_ret_seq;
		s_ret_take |-> ##4 s_idle4;
	endproperty
	a_ret_seq: assert property (p_ret_seq) else $error("return timing wrong");
	property p_ret_target;
		pc_load_q |-> pc_target_q == $past(top_of_return_stack);
	endproperty
	a_ret_target: assert property (p_ret_target) else $error("return target wrong");
	property p_no_take;
		nop_cycle_q |-> !instr_req;
	endproperty
	a_no_take: assert property (p_no_take) else $error("fetch in idle cycle");
	property p_no_ret;
		take && !ret_op |-> ##1 !pc_load_q [*4];
	endproperty
	a_no_ret: assert property (p_no_ret) else $error("spurious return");
	property p_idx_on;
		take && ext_q && acc_op && !instr_word[8] && low_f |=> data_addr_valid_q && data_addr_indexed_q;
	endproperty
	a_idx_on: assert property (p_idx_on) else $error("offset mode missed");
	property p_idx_off;
		take && acc_op && (!ext_q || instr_word[8] || !low_f) |=>
			!data_addr_indexed_q && data_addr_q[7:0] == $past(instr_word[7:0]);
	endproperty
	a_idx_off: assert property (p_idx_off) else $error("literal address wrong");
	property p_class;
		take && instr_word[15:12] == 4'hE |=> !data_addr_valid_q && !data_addr_indexed_q;
	endproperty
	a_class: assert property (p_class) else $error("non access op remapped");
	property p_dest;
		take && byte_op |=> dest_file_q == $past(instr_word[9]);
	endproperty
	a_dest: assert property (p_dest) else $error("destination wrong");
endmodule // ext_index_checker
bind ext_index_decoder ext_index_checker #(.ADDR_W(ADDR_W), .PC_W(PC_W), .DATA_W(DATA_W)) u_chk (.*);

/* test/ext_index_decoder_test.sv */
`timescale 1ns/1ps
module ext_index_decoder_test;
	reg ref_clk, rst_n, clk_en, instr_valid, reg_wr, reg_rd, rd_d;
	reg [15:0] instr_word, reg_wdata;
	reg [3:0] reg_addr;
	reg [20:0] top_of_return_stack;
	wire instr_req, stack_pop_q, pc_load_q, data_addr_valid_q, data_addr_indexed_q, dest_file_q, nop_cycle_q;
	wire [20:0] pc_target_q;
	wire [11:0] data_addr_q;
	wire [3:0] phase_q;
	wire [15:0] reg_rdata_q;
	logic [15:0] exp_q[$];
	logic [21:0] ret_q[$];
	integer fail_count, checks, cyc, i;
	reg [11:0] p, k;
	reg [20:0] t;
	ext_index_decoder i_dut (.*);
	initial
	begin
		ref_clk = 1'b0;
		forever #12.5 ref_clk = ~ref_clk;
	end
	task wrap_up;
	begin
		$display("checks %0d mismatches %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	end
	endtask
	task check(input logic [21:0] seen, input logic [21:0] exp);
	begin
		checks = checks + 1;
		if (seen !== exp)
		begin
			fail_count = fail_count + 1;
			$display("mismatch t=%0t seen %h exp %h", $time, seen, exp);
		end
	end
	endtask
	// ----------------------------------------------------------------
	// Monitor: read data stands only in the cycle after the strobe
	// ----------------------------------------------------------------
	always @(posedge ref_clk)
	begin
		if (rd_d)
			check(reg_rdata_q, exp_q.pop_front());
		if (pc_load_q === 1'b1)
			check({stack_pop_q, pc_target_q}, ret_q.pop_front());
		rd_d <= reg_rd;
		cyc <= cyc + 1;
		if (cyc > 3000)
		begin
			fail_count = fail_count + 1;
			wrap_up;
		end
	end
	task wr(input [3:0] a, input [15:0] d);
	begin
		@(posedge ref_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	end
	endtask
	task rd(input [3:0] a, input [15:0] e);
	begin
		@(posedge ref_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		exp_q.push_back(e);
		@(posedge ref_clk);
		reg_rd <= 1'b0;
	end
	endtask
	// Held until a Q1 edge accepts it; idle return cycle delays this
	task ins(input [15:0] w);
	integer n;
	begin
		@(posedge ref_clk);
		instr_word <= w;
		instr_valid <= 1'b1;
		n = 0;
		do
		begin
			@(posedge ref_clk);
			n = n + 1;
		end
		while (!(phase_q === 4'h1 && instr_req === 1'b1) && n < 20);
		instr_valid <= 1'b0;
	end
	endtask
	task op(input [15:0] w, input [15:0] e);
	begin
		ins(w);
		rd(4'h5, e);
	end
	endtask
	task sub(input [1:0] s, input [5:0] kk);
	begin
		ins({8'hE9, s, kk});
		repeat (3) @(posedge ref_clk);
	end
	endtask
	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial
	begin
		rst_n = 1'b0;
		clk_en = 1'b1;
		instr_valid = 1'b0;
		instr_word = 16'h0000;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 4'h0;
		reg_wdata = 16'h0000;
		top_of_return_stack = 21'h000000;
		rd_d = 1'b0;
		fail_count = 0;
		checks = 0;
		cyc = 0;
		i = $urandom(32'h1be6);
		repeat (2) @(posedge ref_clk);
		rst_n <= 1'b1;
		for (i = 0; i < 7; i = i + 1)
			rd(i[3:0], 16'h0000);
		$display("test reset done");
		wr(4'h1, 16'h0003);
		op(16'h2410, 16'h0010);
		op(16'h2480, 16'h0F80);
		op(16'h2522, 16'h0322);
		$display("test literal done");
		wr(4'h0, 16'h0001);
		rd(4'h0, 16'h0001);
		op(16'h2610, 16'h1010);
		p = 12'($urandom);
		k = 12'($urandom % 96);
		wr(4'h4, {4'h0, p});
		op({8'h24, k[7:0]}, {4'h1, p + k});
		op(16'h265F, {4'h1, p + 12'h05F});
		op(16'h2460, 16'h0F60);
		op({8'h8E, k[7:0]}, {4'h1, p + k});
		op({8'h68, k[7:0]}, {4'h1, p + k});
		op(16'h8F10, 16'h0310);
		op(16'hD010, 16'h0310);
		$display("test indexed done");
		for (i = 0; i < 3; i = i + 1)
		begin
			p = (i == 2) ? 12'h000 : 12'($urandom);
			k = (i == 0) ? 12'h03F : 12'($urandom % 63) + 12'h001;
			wr(i[3:0] + 4'h2, {4'h0, p});
			sub(i[1:0], k[5:0]);
			rd(i[3:0] + 4'h2, {4'h0, p - k});
		end
		$display("test subtract done");
		p = 12'($urandom);
		t = 21'($urandom);
		top_of_return_stack <= t;
		ret_q.push_back({1'b1, t});
		wr(4'h4, {4'h0, p});
		sub(2'h3, 6'h23);
		rd(4'h4, {4'h0, p - 12'h023});
		rd(4'h5, 16'h2310);
		op(16'h2400, {4'h1, p - 12'h023});
		$display("test return done");
		clk_en <= 1'b0;
		wr(4'h4, 16'h0ABC);
		clk_en <= 1'b1;
		rd(4'h4, {4'h0, p - 12'h023});
		$display("test freeze done");
		wr(4'h0, 16'h0000);
		op(16'h2410, 16'h0010);
		$display("test disable done");
		wrap_up;
	end
endmodule // ext_index_decoder_test
